// file: src/gpiop_pkg.sv
// Constants of the eight-bit port: register offsets, field positions,
// reset values and bus widths.
// Assumes a 12-bit byte address from the register port.
package gpiop_pkg;

  // ------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------
  localparam int GPIOP_ADDR_WIDTH = 12;
  localparam int GPIOP_DATA_WIDTH = 32;
  localparam int GPIOP_PIN_COUNT  = 8;

  // Address lines that carry the per-bit access mask
  localparam int GPIOP_MASK_LSB   = 2;
  localparam int GPIOP_MASK_MSB   = 9;
  // Address lines that select the aliased pin value window
  localparam int GPIOP_WIN_LSB    = 10;
  localparam int GPIOP_WIN_MSB    = 11;
  localparam logic [1:0] GPIOP_WIN_PIN_VALUE = 2'h0;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [11:0] GPIOP_OFS_PIN_VALUE     = 12'h000;
  localparam logic [11:0] GPIOP_OFS_OUTPUT_ENABLE = 12'h400;
  localparam logic [11:0] GPIOP_OFS_SENSE         = 12'h404;
  localparam logic [11:0] GPIOP_OFS_DUAL_EDGE     = 12'h408;
  localparam logic [11:0] GPIOP_OFS_POLARITY      = 12'h40c;
  localparam logic [11:0] GPIOP_OFS_MASK          = 12'h410;
  localparam logic [11:0] GPIOP_OFS_RAW_STATUS    = 12'h414;
  localparam logic [11:0] GPIOP_OFS_MASKED_STATUS = 12'h418;
  localparam logic [11:0] GPIOP_OFS_CLEAR         = 12'h41c;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0]  GPIOP_RST_PIN_VALUE     = 8'h00;
  localparam logic [7:0]  GPIOP_RST_OUTPUT_ENABLE = 8'h00;
  localparam logic [7:0]  GPIOP_RST_SENSE         = 8'h00;
  localparam logic [7:0]  GPIOP_RST_DUAL_EDGE     = 8'h00;
  localparam logic [7:0]  GPIOP_RST_POLARITY      = 8'h00;
  localparam logic [7:0]  GPIOP_RST_MASK          = 8'h00;
  localparam logic [7:0]  GPIOP_RST_STATUS        = 8'h00;
  localparam logic [31:0] GPIOP_RST_READ_DATA     = 32'h0000_0000;

endpackage

// file: src/gpiop_port.sv
// Eight-bit general-purpose port: data, direction, trigger
// configuration, trigger status and one combined interrupt.
// Assumes a single-cycle register port whose master never
// raises both strobes at once, and pins synchronous to CLK.
`timescale 1ns/1ps

module gpiop_port
  import gpiop_pkg::*;
#(
  parameter int N = GPIOP_PIN_COUNT
) (
  input  wire logic                        CLK,
  input  wire logic                        RST,
  input  wire logic [GPIOP_ADDR_WIDTH-1:0] ADDR,
  input  wire logic [GPIOP_DATA_WIDTH-1:0] WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [GPIOP_DATA_WIDTH-1:0] RDATA,
  input  wire logic [N-1:0]                PIN_IN,
  output logic      [N-1:0]                PIN_OUT,
  output logic      [N-1:0]                PIN_OE,
  output logic      [N-1:0]                PIN_IRQ,
  output logic                             IRQ
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [N-1:0]                pin_value;
    logic [N-1:0]                output_enable;
    logic [N-1:0]                sense;
    logic [N-1:0]                dual_edge;
    logic [N-1:0]                polarity;
    logic [N-1:0]                mask;
    logic [N-1:0]                status;
    logic [N-1:0]                pin_irq;
    logic [GPIOP_DATA_WIDTH-1:0] read_data;
    logic                        irq;
  } gpiop_state_type;

  localparam gpiop_state_type GPIOP_STATE_RESET = '{
    pin_value:     GPIOP_RST_PIN_VALUE[N-1:0],
    output_enable: GPIOP_RST_OUTPUT_ENABLE[N-1:0],
    sense:         GPIOP_RST_SENSE[N-1:0],
    dual_edge:     GPIOP_RST_DUAL_EDGE[N-1:0],
    polarity:      GPIOP_RST_POLARITY[N-1:0],
    mask:          GPIOP_RST_MASK[N-1:0],
    status:        GPIOP_RST_STATUS[N-1:0],
    pin_irq:       GPIOP_RST_STATUS[N-1:0],
    read_data:     GPIOP_RST_READ_DATA,
    irq:           1'b0
  };

  gpiop_state_type s_reg;
  gpiop_state_type s_next;

  // ------------------------------------------------------------
  // Trigger detection
  // ------------------------------------------------------------
  logic [N-1:0] pin_sample;
  logic [N-1:0] trigger_hit;

  gpiop_trigger #(
    .N (N)
  ) u_trigger (
    .clk              (CLK),
    .rst              (RST),
    .pin_level        (PIN_IN),
    .trigger_sense    (s_reg.sense),
    .dual_edge_select (s_reg.dual_edge),
    .trigger_polarity (s_reg.polarity),
    .pin_sample       (pin_sample),
    .trigger_hit      (trigger_hit)
  );

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  logic         in_value_window;
  logic [N-1:0] access_mask;
  logic         sel_output_enable;
  logic         sel_sense;
  logic         sel_dual_edge;
  logic         sel_polarity;
  logic         sel_mask;
  logic         sel_raw_status;
  logic         sel_masked_status;
  logic         sel_clear;

  // Whole window below the control block is one register
  assign in_value_window   = (ADDR[GPIOP_WIN_MSB:GPIOP_WIN_LSB] == GPIOP_WIN_PIN_VALUE);
  assign access_mask       = ADDR[GPIOP_MASK_LSB +: N];
  assign sel_output_enable = (ADDR == GPIOP_OFS_OUTPUT_ENABLE);
  assign sel_sense         = (ADDR == GPIOP_OFS_SENSE);
  assign sel_dual_edge     = (ADDR == GPIOP_OFS_DUAL_EDGE);
  assign sel_polarity      = (ADDR == GPIOP_OFS_POLARITY);
  assign sel_mask          = (ADDR == GPIOP_OFS_MASK);
  assign sel_raw_status    = (ADDR == GPIOP_OFS_RAW_STATUS);
  assign sel_masked_status = (ADDR == GPIOP_OFS_MASKED_STATUS);
  assign sel_clear         = (ADDR == GPIOP_OFS_CLEAR);

  // ------------------------------------------------------------
  // Pin view and status updates
  // ------------------------------------------------------------
  logic [N-1:0] pin_view;
  logic [N-1:0] write_bits;
  logic [N-1:0] clear_bits;
  logic [N-1:0] masked_status;

  // Outputs show the driven value, inputs the sampled level
  assign pin_view = (s_reg.output_enable & s_reg.pin_value)
                  | (~s_reg.output_enable & pin_sample);

  // Only unmasked output bits take a write
  assign write_bits = access_mask & s_reg.output_enable;

  assign masked_status = s_reg.status & s_reg.mask;

  // Clear by writing ones, or by reading either status view
  always_comb begin
    clear_bits = '0;
    if (WR && sel_clear) begin
      clear_bits = WDATA[N-1:0];
    end else if (RD && (sel_raw_status || sel_masked_status)) begin
      clear_bits = {N{1'b1}};
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_next           = s_reg;
    s_next.read_data = '0;

    // Register writes; only the low bits hold state
    if (WR) begin
      if (in_value_window) begin
        s_next.pin_value = (s_reg.pin_value & ~write_bits)
                         | (WDATA[N-1:0] & write_bits);
      end
      if (sel_output_enable) begin
        s_next.output_enable = WDATA[N-1:0];
      end
      if (sel_sense) begin
        s_next.sense = WDATA[N-1:0];
      end
      if (sel_dual_edge) begin
        s_next.dual_edge = WDATA[N-1:0];
      end
      if (sel_polarity) begin
        s_next.polarity = WDATA[N-1:0];
      end
      if (sel_mask) begin
        s_next.mask = WDATA[N-1:0];
      end
    end

    // New detections win over a clear in the same cycle
    s_next.status = (s_reg.status & ~clear_bits) | trigger_hit;

    // Register reads; reserved and unmapped bits read as zero
    if (RD) begin
      if (in_value_window) begin
        s_next.read_data[N-1:0] = pin_view & access_mask;
      end else if (sel_output_enable) begin
        s_next.read_data[N-1:0] = s_reg.output_enable;
      end else if (sel_sense) begin
        s_next.read_data[N-1:0] = s_reg.sense;
      end else if (sel_dual_edge) begin
        s_next.read_data[N-1:0] = s_reg.dual_edge;
      end else if (sel_polarity) begin
        s_next.read_data[N-1:0] = s_reg.polarity;
      end else if (sel_mask) begin
        s_next.read_data[N-1:0] = s_reg.mask;
      end else if (sel_raw_status) begin
        s_next.read_data[N-1:0] = s_reg.status;
      end else if (sel_masked_status) begin
        s_next.read_data[N-1:0] = masked_status;
      end else begin
        s_next.read_data = '0;
      end
    end

    // Interrupts gated by the trigger mask
    s_next.pin_irq = s_next.status & s_next.mask;
    s_next.irq     = |(s_next.status & s_next.mask);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      s_reg <= GPIOP_STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign RDATA   = s_reg.read_data;
  assign PIN_OUT = s_reg.pin_value;
  assign PIN_OE  = s_reg.output_enable;
  assign PIN_IRQ = s_reg.pin_irq;
  assign IRQ     = s_reg.irq;

endmodule // gpiop_port

// file: src/gpiop_trigger.sv
// Per-pin sampling and trigger detection of the port.
// Assumes pin levels are synchronous to the clock.
`timescale 1ns/1ps
module gpiop_trigger
  import gpiop_pkg::*;
#(
  parameter int N = GPIOP_PIN_COUNT
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [N-1:0] pin_level,
  input  wire logic [N-1:0] trigger_sense,
  input  wire logic [N-1:0] dual_edge_select,
  input  wire logic [N-1:0] trigger_polarity,
  output logic      [N-1:0] pin_sample,
  output logic      [N-1:0] trigger_hit
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [N-1:0] sample;
    logic [N-1:0] previous;
    logic         sampled;
    logic         primed;
  } gpiop_trig_state_type;

  gpiop_trig_state_type t_reg;
  gpiop_trig_state_type t_next;

  // Sample now, keep the sample before it
  always_comb begin
    t_next          = t_reg;
    t_next.sample   = pin_level;
    t_next.previous = t_reg.sample;
    // Previous sample is real only one cycle after the first one
    t_next.sampled  = 1'b1;
    t_next.primed   = t_reg.sampled;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  assign pin_sample = t_reg.sample;

  // ------------------------------------------------------------
  // Trigger selection per pin
  // ------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < N; b++) begin : g_pin
      logic rise;
      logic fall;
      logic edge_hit;
      logic level_hit;
      // No edge from the reset value on the first sample
      assign rise      = t_reg.primed & t_reg.sample[b] & ~t_reg.previous[b];
      assign fall      = t_reg.primed & ~t_reg.sample[b] & t_reg.previous[b];
      assign edge_hit  = dual_edge_select[b] ? (rise | fall)
                       : (trigger_polarity[b] ? rise : fall);
      assign level_hit = trigger_polarity[b] ? t_reg.sample[b] : ~t_reg.sample[b];
      assign trigger_hit[b] = trigger_sense[b] ? level_hit : edge_hit;
    end
  endgenerate

endmodule // gpiop_trigger

// file: verification/gpiop_pin_model.sv
// Far side of the port: the eight pins.
// Assumes the bench gives the level of undriven pins.
`timescale 1ns/1ps
module gpiop_pin_model (
  input  wire logic [7:0] ext_level,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  output logic      [7:0] pin_level
);
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // gpiop_pin_model

// file: verification/gpiop_port_props.sv
// Checker of the port's bus and pin relations.
// Assumes a bind onto gpiop_port; sees its ports only.
`timescale 1ns/1ps
module gpiop_port_props
  import gpiop_pkg::*;
#(
  parameter int N = GPIOP_PIN_COUNT
) (
  input wire logic         CLK,
  input wire logic         RST,
  input wire logic [11:0]  ADDR,
  input wire logic [31:0]  WDATA,
  input wire logic         WR,
  input wire logic         RD,
  input wire logic [31:0]  RDATA,
  input wire logic [N-1:0] PIN_IN,
  input wire logic [N-1:0] PIN_OUT,
  input wire logic [N-1:0] PIN_OE,
  input wire logic [N-1:0] PIN_IRQ,
  input wire logic         IRQ
);
  logic         pv_sel;
  logic [N-1:0] wmask;
  assign pv_sel = ADDR[11:10] == 2'h0;
  assign wmask  = ADDR[9:2] & PIN_OE;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  AST_PIN_RESET: assert property (disable iff (1'b0) $fell(RST) |-> PIN_OE == '0 && PIN_OUT == '0)
    else $error("Pins not cleared");
  AST_OE_WRITE: assert property (WR && ADDR == GPIOP_OFS_OUTPUT_ENABLE |=> PIN_OE == $past(WDATA[N-1:0]))
    else $error("Output enable write lost");
  AST_PV_WRITE:
    assert property (WR && pv_sel |=> PIN_OUT == (($past(WDATA[N-1:0]) & $past(wmask)) | ($past(PIN_OUT) & ~$past(wmask))))
    else $error("Masked write wrong");
  AST_PV_HOLD: assert property (!(WR && pv_sel) |=> $stable(PIN_OUT))
    else $error("Pin value changed");
  AST_RD_MASK: assert property (RD && pv_sel |=> (RDATA[N-1:0] & ~$past(ADDR[9:2])) == '0)
    else $error("Masked read bit set");
  AST_RD_OUT: assert property (RD && pv_sel |=> (RDATA[N-1:0] & $past(PIN_OE)) == $past(wmask & PIN_OUT))
    else $error("Output read wrong");
  AST_RD_HIGH: assert property (RD |=> RDATA[31:8] == '0)
    else $error("Upper read bits set");
  AST_IRQ_ANY: assert property (IRQ == |PIN_IRQ)
    else $error("Combined interrupt wrong");
  AST_IRQ_MASK:
    assert property (WR && ADDR == GPIOP_OFS_MASK && WDATA[N-1:0] == '0 ##1 !WR |=> PIN_IRQ == '0)
    else $error("Masked pin interrupt");
  COV_PV_WRITE: cover property (WR && pv_sel);
  COV_IRQ_RISE: cover property ($rose(IRQ));
  COV_PV_READ: cover property (RD && pv_sel ##1 RDATA != '0);
endmodule // gpiop_port_props

// file: verification/gpiop_port_tb.sv
// Self-checking bench of the port against an integer model.
// Assumes gpiop_port, gpiop_pin_model and the checker.
`timescale 1ns/1ps
module gpiop_port_tb;
  import gpiop_pkg::*;
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic [11:0] ADDR = 12'h000;
  logic [31:0] WDATA = 32'h0000_0000;
  logic [7:0]  ext_level = 8'h00;
  logic [31:0] RDATA;
  logic [7:0]  PIN_IN, PIN_OUT, PIN_OE, PIN_IRQ;
  logic        IRQ;
  logic [31:0] exp_q[$];
  int          fail_count = 0;
  int          checks = 0;
  int          cyc = 0;
  int          oe, pv, d, m, mk, s, de, pl;

  initial begin
    forever #2 CLK = ~CLK;
  end

  gpiop_port #(.N(8)) dut_u (
    .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_IRQ(PIN_IRQ), .IRQ(IRQ));
  gpiop_pin_model pins_u (.ext_level(ext_level), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .pin_level(PIN_IN));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One bus cycle; a checked read queues its word
  task automatic op(input logic w, input logic r, input logic c, input logic [11:0] a, input logic [31:0] v);
    WR <= w;
    RD <= r;
    ADDR <= a;
    WDATA <= v;
    @(posedge CLK);
    if (c) begin
      exp_q.push_back(v);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    op(1'b1, 1'b0, 1'b0, a, v);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] v);
    op(1'b0, 1'b1, 1'b1, a, v);
  endtask
  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 1'b0, 12'h000, 32'h0000_0000);
  endtask

  always @(negedge CLK) begin
    if (exp_q.size() != 0) begin
      chk(RDATA, exp_q.pop_front());
    end
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      tally_and_finish;
    end
  end

  initial begin
    void'($urandom(24511));
    pv = 0;
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    rd(12'h3fc, 0);
    for (int i = 0; i < 5; i++) rd(12'h400 + 12'(4 * i), 0);
    rd(GPIOP_OFS_CLEAR, 0);
    rd(12'hffc, 0);
    for (int i = 0; i < 5; i++) begin
      d = $urandom & 255;
      wr(12'h400 + 12'(4 * i), d);
      rd(12'h400 + 12'(4 * i), d);
    end
    for (int i = 0; i < 24; i++) begin
      oe = $urandom & 255;
      d = $urandom & 255;
      m = $urandom & 255;
      ext_level <= 8'($urandom);
      wr(GPIOP_OFS_OUTPUT_ENABLE, oe);
      wr(12'(m * 4 + $urandom % 4), d);
      pv = (pv & ~(m & oe)) | (d & m & oe);
      idle(1);
      @(negedge CLK);
      chk(PIN_OUT, pv);
      chk(PIN_OE, oe);
      chk(PIN_IN, (oe & pv) | (~oe & ext_level));
      @(posedge CLK);
      m = $urandom & 255;
      rd(12'(m * 4), m & ((oe & pv) | (~oe & ext_level)));
    end
    wr(GPIOP_OFS_OUTPUT_ENABLE, 0);
    for (int c = 0; c < 8; c++) begin
      s = c / 4;
      de = (c / 2) % 2;
      pl = c % 2;
      mk = $urandom & 255;
      ext_level <= pl ? 8'h00 : 8'hff;
      wr(GPIOP_OFS_SENSE, s * 255);
      wr(GPIOP_OFS_DUAL_EDGE, de * 255);
      wr(GPIOP_OFS_POLARITY, pl * 255);
      wr(GPIOP_OFS_MASK, mk);
      idle(4);
      op(1'b0, 1'b1, 1'b0, GPIOP_OFS_RAW_STATUS, 0);
      rd(GPIOP_OFS_RAW_STATUS, 0);
      ext_level <= ~ext_level;
      idle(4);
      @(negedge CLK);
      chk(PIN_IRQ, mk);
      chk(IRQ, mk != 0);
      @(posedge CLK);
      rd(GPIOP_OFS_MASKED_STATUS, mk);
      rd(GPIOP_OFS_RAW_STATUS, s * 255);
      ext_level <= ~ext_level;
      idle(4);
      rd(GPIOP_OFS_RAW_STATUS, (s | de) * 255);
      rd(GPIOP_OFS_RAW_STATUS, 0);
    end
    wr(GPIOP_OFS_SENSE, 0);
    ext_level <= 8'hff;
    idle(4);
    wr(GPIOP_OFS_CLEAR, 32'h0000_000f);
    wr(GPIOP_OFS_CLEAR, 0);
    rd(GPIOP_OFS_RAW_STATUS, 32'h0000_00f0);
    wr(GPIOP_OFS_MASK, 0);
    idle(3);
    // Mid-run reset with driven outputs and a high input level
    wr(GPIOP_OFS_OUTPUT_ENABLE, 32'h0000_00ff);
    wr(12'h3fc, 32'h0000_00a5);
    idle(1);
    RST <= 1'b1;
    idle(2);
    RST <= 1'b0;
    wr(GPIOP_OFS_POLARITY, 32'h0000_00ff);
    idle(3);
    rd(GPIOP_OFS_RAW_STATUS, 0);
    @(negedge CLK);
    chk(PIN_OUT, 0);
    chk(PIN_OE, 0);
    @(posedge CLK);
    rd(12'h3fc, 32'h0000_00ff);
    idle(2);
    tally_and_finish;
  end
endmodule // gpiop_port_tb

bind gpiop_port gpiop_port_props #(.N(N)) props_u (
  .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_IRQ(PIN_IRQ), .IRQ(IRQ));
